// ==== core/sdrpi_pkg.sv ====
// shared constants and types for the dual-rank sdram pin controller
package sdrpi_pkg;

  // ----------------------------------------------------------------
  // clocking and latency
  // ----------------------------------------------------------------
  localparam int unsigned REF_PERIOD_NS = 100;
  localparam int unsigned CK_DIV        = 4;   // ref cycles per ck period
  localparam int unsigned CK_PERIOD_NS  = REF_PERIOD_NS * CK_DIV;
  localparam logic [1:0]  PHASE_LAST    = 2'(CK_DIV - 1);
  localparam int unsigned CWL_CK        = 5;   // write latency in ck cycles
  localparam int unsigned CL_CK         = 6;   // read latency in ck cycles
  localparam logic [3:0]  WR_LAT_CNT    = 4'(CWL_CK - 1);
  localparam logic [3:0]  RD_LAT_CNT    = 4'(CL_CK - 1);

  // ----------------------------------------------------------------
  // burst and address fields
  // ----------------------------------------------------------------
  localparam int unsigned BEATS      = 8;
  localparam logic [2:0]  LAST_BL8   = 3'h7;
  localparam logic [2:0]  LAST_BC4   = 3'h3;
  localparam logic [15:0] A10_MASK   = 16'h0400;
  localparam logic [15:0] A12_MASK   = 16'h1000;
  localparam int unsigned A10_BIT    = 10;
  localparam int unsigned A12_BIT    = 12;

  // ----------------------------------------------------------------
  // command pin codes {ras_n, cas_n, we_n} and rank selects
  // ----------------------------------------------------------------
  localparam logic [2:0] RCW_ACT = 3'h3;
  localparam logic [2:0] RCW_RD  = 3'h5;
  localparam logic [2:0] RCW_WR  = 3'h4;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_NOP = 3'h7;
  localparam logic [1:0] CS_NONE = 2'h3;
  localparam logic [1:0] RANK0   = 2'h1;
  localparam logic [1:0] RANK1   = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD  = 4'h2, OP_WR  = 4'h3,
    OP_PRE = 4'h4, OP_MRS = 4'h5, OP_REF = 4'h6, OP_PDE = 4'h7,
    OP_PDX = 4'h8, OP_SRE = 4'h9, OP_SRX = 4'ha
  } sdrpi_op_t;

  typedef struct packed {
    sdrpi_op_t   op;
    logic        rank;
    logic [2:0]  bank;
    logic [15:0] addr;
    logic        auto_pre;
    logic        bc4;
    logic        all_banks;
    logic [1:0]  mr_sel;
    logic [63:0] wdata;
    logic [7:0]  wmask;
  } sdrpi_req_t;

  typedef struct packed {
    logic [1:0]  cke;
    logic [1:0]  cs_n;
    logic [2:0]  rcw;
    logic [2:0]  ba;
    logic [15:0] a;
    logic [1:0]  odt;
  } sdrpi_ca_t;

  localparam sdrpi_ca_t CA_RST = '{cke: 2'h0, cs_n: CS_NONE, rcw: RCW_NOP,
                                   ba: 3'h0, a: 16'h0000, odt: 2'h0};

endpackage : sdrpi_pkg

// ==== core/sdrpi_burst.sv ====
// eight-beat (four-beat when chopped) data serializer and read capture for the sdram data pins
`timescale 1ns/1ps
`default_nettype none
module sdrpi_burst (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        wr_go_i,
  input  wire logic        rd_go_i,
  input  wire logic        bc4_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic [7:0]  wmask_i,
  input  wire logic [7:0]  dq_sync_i,
  output logic      [7:0]  dq_o,
  output logic             dm_o,
  output logic             dq_oe_n_o,
  output logic             dqs_o,
  output logic      [63:0] rdata_o,
  output logic             rd_valid_o,
  output logic             done_o
);

  logic        active_reg;
  logic        write_reg;
  logic        bc4_reg;
  logic        sub_reg;
  logic [2:0]  beat_reg;
  logic [63:0] wdata_reg;
  logic [7:0]  wmask_reg;
  logic [7:0]  dq_reg;
  logic        dm_reg;
  logic        dqs_reg;
  logic        oe_n_reg;
  logic        done_reg;
  logic [7:0]  rbeat_reg [sdrpi_pkg::BEATS];

  wire logic [2:0] beat_nx = beat_reg + 3'h1;
  wire logic       last    = beat_reg == (bc4_reg ? sdrpi_pkg::LAST_BC4 : sdrpi_pkg::LAST_BL8);
  wire logic       step    = active_reg && sub_reg;
  wire logic       go      = wr_go_i || rd_go_i;

  // ----------------------------------------------------------------
  // beat sequencer: two ref cycles per beat, one beat per half ck
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_reg <= 1'b0;
      write_reg  <= 1'b0;
      bc4_reg    <= 1'b0;
      sub_reg    <= 1'b0;
      beat_reg   <= 3'h0;
      wdata_reg  <= 64'h0;
      wmask_reg  <= 8'h00;
      oe_n_reg   <= 1'b1;
    end else if (go) begin
      active_reg <= 1'b1;
      write_reg  <= wr_go_i;
      bc4_reg    <= bc4_i;
      sub_reg    <= 1'b0;
      beat_reg   <= 3'h0;
      wdata_reg  <= wdata_i;
      wmask_reg  <= wmask_i;
      oe_n_reg   <= ~wr_go_i;
    end else if (active_reg) begin
      sub_reg <= ~sub_reg;
      if (step && last) begin
        active_reg <= 1'b0;
        oe_n_reg   <= 1'b1;
      end else if (step) begin
        beat_reg <= beat_nx;
      end
    end
  end

  // write beats launch at the beat start, strobe flips mid-beat
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_reg  <= 8'h00;
      dm_reg  <= 1'b0;
      dqs_reg <= 1'b0;
    end else if (wr_go_i) begin
      dq_reg  <= wdata_i[7:0];
      dm_reg  <= wmask_i[0];
      dqs_reg <= 1'b0;
    end else if (active_reg && write_reg) begin
      if (!sub_reg) begin
        dqs_reg <= ~beat_reg[0];
      end else if (!last) begin
        dq_reg <= wdata_reg[{beat_nx, 3'h0} +: 8];
        dm_reg <= wmask_reg[beat_nx];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= step && last;
    end
  end

  // ----------------------------------------------------------------
  // read capture, one slot per beat
  // ----------------------------------------------------------------
  for (genvar k = 0; k < sdrpi_pkg::BEATS; k++) begin : g_cap
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rbeat_reg[k] <= 8'h00;
      end else if (step && !write_reg && beat_reg == 3'(k)) begin
        rbeat_reg[k] <= dq_sync_i;
      end
    end
    assign rdata_o[k*8 +: 8] = rbeat_reg[k];
  end

  assign dq_o       = dq_reg;
  assign dm_o       = dm_reg;
  assign dqs_o      = dqs_reg;
  assign dq_oe_n_o  = oe_n_reg;
  assign done_o     = done_reg;
  assign rd_valid_o = done_reg && !write_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_wr_mask;
    wr_go_i |=> (dm_o == $past(wmask_i[0])) ##2 (dm_o == $past(wmask_i[1], 3));
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write mask beat mismatch");

  sequence s_drive8;
    (!dq_oe_n_o)[*8];
  endsequence

  property p_bl8_len;
    wr_go_i && !bc4_i |=> s_drive8 ##1 s_drive8 ##1 dq_oe_n_o;
  endproperty
  a_bl8_len: assert property (p_bl8_len) else $error("bl8 write not 8 beats");

  property p_bc4_len;
    wr_go_i && bc4_i |=> s_drive8 ##1 dq_oe_n_o;
  endproperty
  a_bc4_len: assert property (p_bc4_len) else $error("bc4 write not 4 beats");

  property p_dqs_center;
    $past(!dq_oe_n_o) && !dq_oe_n_o && $changed(dqs_o) |-> $stable(dq_o);
  endproperty
  a_dqs_center: assert property (p_dqs_center) else $error("strobe edge not mid-beat");

endmodule : sdrpi_burst
`default_nettype wire

// ==== core/sdrpi_host.sv ====
// host-side command, address and data pin controller for a two-rank sdram
//
// Contract
// - activate puts row on address; read/write put column, a10 requests auto-precharge.
// - precharge a10 low closes the bank on ba, high closes all banks.
// - load mode places the mode op-code on the address pins.
// - with on-the-fly chop, a12 high means 8 beats, low means 4.
// - bank bits pick one of eight banks for bank commands.
// - during load mode the bank bits pick mode register zero to three.
// - all command pins are sampled at ck rising; hold them around it.
// - cke low enters precharge/active power-down or self refresh per bank state.
// - cke sync for power-down and self refresh entry, async for self refresh exit.
// - controller selects a rank by asserting only that rank's chip select.
// - command is chip select plus ras, cas and we decoded together.
// - write beats with data mask high are not stored.
// - reset is active low, asserted and released asynchronously.
// - x4 parts move data over four bidirectional bits.
// - read strobe edge-aligned from device, write strobe centred from controller.
// - each access moves eight bus-wide beats, four when chopped, one per half ck.
// - x8 parts move data over eight bidirectional bits.
`timescale 1ns/1ps
`default_nettype none
module sdrpi_host (
  input  wire logic                 REF_CLK_I,
  input  wire logic                 ARST_N_I,
  input  wire sdrpi_pkg::sdrpi_req_t REQ_I,
  input  wire logic                 REQ_VALID_I,
  output logic                      REQ_READY_O,
  input  wire logic [1:0]           ODT_EN_I,
  input  wire logic                 MEM_RST_I,
  output logic      [63:0]          RDATA_O,
  output logic                      RDATA_VALID_O,
  output logic                      BUSY_O,
  output logic                      CK_O,
  output logic                      CK_N_O,
  output logic      [1:0]           CKE_O,
  output logic      [1:0]           CS_N_O,
  output logic                      RAS_N_O,
  output logic                      CAS_N_O,
  output logic                      WE_N_O,
  output logic      [2:0]           BA_O,
  output logic      [15:0]          A_O,
  output logic      [1:0]           ODT_O,
  output logic                      RESET_N_O,
  output logic                      DM_O,
  input  wire logic [7:0]           DQ_I,
  output logic      [7:0]           DQ_O,
  output logic                      DQ_OE_N_O,
  output logic                      DQS_O,
  output logic                      DQS_N_O,
  output logic                      DQS_OE_N_O
);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ISSUE  = 3'h1,
    ST_WLAT   = 3'h2,
    ST_WBURST = 3'h3,
    ST_RLAT   = 3'h4,
    ST_RBURST = 3'h5
  } sdrpi_state_t;

  sdrpi_state_t          state_reg;
  sdrpi_state_t          state_next;
  logic [3:0]            lat_reg;
  logic [3:0]            lat_next;
  logic [1:0]            phase_reg;
  logic                  rst_n_reg;
  sdrpi_pkg::sdrpi_ca_t  ca_reg;
  sdrpi_pkg::sdrpi_ca_t  ca_next;
  sdrpi_pkg::sdrpi_req_t req_reg;
  logic [7:0]            dq_s1_reg;
  logic [7:0]            dq_s2_reg;
  logic                  wr_go;
  logic                  rd_go;
  logic                  burst_done;
  logic                  dqs_int;

  // ----------------------------------------------------------------
  // ck divider: ck high in the upper half of the phase count
  // ----------------------------------------------------------------
  // pins launch at the ck fall, so each command sits a half ck either
  // side of the rising edge the device samples on
  wire logic tick   = phase_reg == sdrpi_pkg::PHASE_LAST;
  wire logic accept = tick && state_reg == ST_IDLE && REQ_VALID_I;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // command and address decode
  // ----------------------------------------------------------------
  wire sdrpi_pkg::sdrpi_op_t op = REQ_I.op;
  wire logic [1:0] rank_sel = REQ_I.rank ? sdrpi_pkg::RANK1 : sdrpi_pkg::RANK0;
  wire logic is_bus = op == sdrpi_pkg::OP_ACT || op == sdrpi_pkg::OP_RD || op == sdrpi_pkg::OP_WR ||
                      op == sdrpi_pkg::OP_PRE || op == sdrpi_pkg::OP_MRS || op == sdrpi_pkg::OP_REF ||
                      op == sdrpi_pkg::OP_SRE;
  wire logic cke_down = op == sdrpi_pkg::OP_PDE || op == sdrpi_pkg::OP_SRE;
  wire logic cke_up   = op == sdrpi_pkg::OP_PDX || op == sdrpi_pkg::OP_SRX;

  wire logic [2:0] rcw =
    (op == sdrpi_pkg::OP_ACT) ? sdrpi_pkg::RCW_ACT :
    (op == sdrpi_pkg::OP_RD)  ? sdrpi_pkg::RCW_RD  :
    (op == sdrpi_pkg::OP_WR)  ? sdrpi_pkg::RCW_WR  :
    (op == sdrpi_pkg::OP_PRE) ? sdrpi_pkg::RCW_PRE :
    (op == sdrpi_pkg::OP_MRS) ? sdrpi_pkg::RCW_MRS :
    (op == sdrpi_pkg::OP_REF || op == sdrpi_pkg::OP_SRE) ? sdrpi_pkg::RCW_REF : sdrpi_pkg::RCW_NOP;

  // column form: a10 carries auto-precharge, a12 high asks for the full burst
  wire logic [15:0] a_col = (REQ_I.addr & ~(sdrpi_pkg::A10_MASK | sdrpi_pkg::A12_MASK)) |
                            (REQ_I.auto_pre ? sdrpi_pkg::A10_MASK : 16'h0000) |
                            (REQ_I.bc4 ? 16'h0000 : sdrpi_pkg::A12_MASK);
  wire logic [15:0] a_pre = (REQ_I.addr & ~sdrpi_pkg::A10_MASK) |
                            (REQ_I.all_banks ? sdrpi_pkg::A10_MASK : 16'h0000);
  wire logic [15:0] a_sel = (op == sdrpi_pkg::OP_RD || op == sdrpi_pkg::OP_WR) ? a_col :
                            (op == sdrpi_pkg::OP_PRE) ? a_pre : REQ_I.addr;
  wire logic [2:0]  ba_sel = (op == sdrpi_pkg::OP_MRS) ? {1'b0, REQ_I.mr_sel}
                                                       : REQ_I.bank;

  // self refresh exit only raises cke; the device needs no clock edge for it
  wire logic [1:0] cke_sel = cke_down ? (ca_reg.cke & ~rank_sel) :
                             cke_up   ? (ca_reg.cke | rank_sel) : ca_reg.cke;

  always_comb begin
    ca_next = ca_reg;
    if (accept) begin
      ca_next.cke  = cke_sel;
      ca_next.cs_n = is_bus ? ~rank_sel : sdrpi_pkg::CS_NONE;
      ca_next.rcw  = is_bus ? rcw : sdrpi_pkg::RCW_NOP;
      ca_next.ba   = ba_sel;
      ca_next.a    = a_sel;
      ca_next.odt  = ODT_EN_I;
    end else if (tick) begin
      ca_next.cs_n = sdrpi_pkg::CS_NONE;
      ca_next.rcw  = sdrpi_pkg::RCW_NOP;
      ca_next.odt  = ODT_EN_I;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: issue, wait latency, run the data burst
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    lat_next   = lat_reg;
    wr_go      = 1'b0;
    rd_go      = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept && (op == sdrpi_pkg::OP_RD || op == sdrpi_pkg::OP_WR)) begin
          state_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (tick) begin
          state_next = (req_reg.op == sdrpi_pkg::OP_WR) ? ST_WLAT : ST_RLAT;
          lat_next   = (req_reg.op == sdrpi_pkg::OP_WR) ? sdrpi_pkg::WR_LAT_CNT : sdrpi_pkg::RD_LAT_CNT;
        end
      end
      ST_WLAT, ST_RLAT: begin
        if (tick && lat_reg == 4'h0) begin
          wr_go      = state_reg == ST_WLAT;
          rd_go      = state_reg == ST_RLAT;
          state_next = (state_reg == ST_WLAT) ? ST_WBURST : ST_RBURST;
        end else if (tick) begin
          lat_next = lat_reg - 4'h1;
        end
      end
      ST_WBURST, ST_RBURST: begin
        if (burst_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= ST_IDLE;
      lat_reg   <= 4'h0;
      ca_reg    <= sdrpi_pkg::CA_RST;
      rst_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lat_reg   <= lat_next;
      ca_reg    <= ca_next;
      rst_n_reg <= ~MEM_RST_I;
    end
  end

  // request held for the data phase; no reset needed, only read after accept
  always_ff @(posedge REF_CLK_I) begin
    if (accept) begin
      req_reg <= REQ_I;
    end
  end

  // read data arrives from the pins, two flops before any logic sees it;
  // a four-bit part carries its data on the low nibble only
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= DQ_I;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  sdrpi_burst u_burst (
    .clk_i      (REF_CLK_I),
    .arst_n_i   (ARST_N_I),
    .wr_go_i    (wr_go),
    .rd_go_i    (rd_go),
    .bc4_i      (req_reg.bc4),
    .wdata_i    (req_reg.wdata),
    .wmask_i    (req_reg.wmask),
    .dq_sync_i  (dq_s2_reg),
    .dq_o       (DQ_O),
    .dm_o       (DM_O),
    .dq_oe_n_o  (DQ_OE_N_O),
    .dqs_o      (dqs_int),
    .rdata_o    (RDATA_O),
    .rd_valid_o (RDATA_VALID_O),
    .done_o     (burst_done)
  );

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  assign REQ_READY_O = tick && state_reg == ST_IDLE;
  assign BUSY_O      = state_reg != ST_IDLE;
  assign CK_O        = phase_reg[1];
  assign CK_N_O      = ~phase_reg[1];
  assign CKE_O       = ca_reg.cke;
  assign CS_N_O      = ca_reg.cs_n;
  assign RAS_N_O     = ca_reg.rcw[2];
  assign CAS_N_O     = ca_reg.rcw[1];
  assign WE_N_O      = ca_reg.rcw[0];
  assign BA_O        = ca_reg.ba;
  assign A_O         = ca_reg.a;
  assign ODT_O       = ca_reg.odt;
  assign RESET_N_O   = rst_n_reg;
  assign DQS_O       = dqs_int;
  assign DQS_N_O     = ~dqs_int;
  assign DQS_OE_N_O  = DQ_OE_N_O;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_cs_excl;
    $onehot0(~CS_N_O);
  endproperty
  a_cs_excl: assert property (p_cs_excl) else $error("two chip selects active");

  property p_rd_ap;
    accept && op == sdrpi_pkg::OP_RD |=> A_O[sdrpi_pkg::A10_BIT] == $past(REQ_I.auto_pre) &&
                                        CS_N_O == ~$past(rank_sel) && {RAS_N_O, CAS_N_O, WE_N_O} == sdrpi_pkg::RCW_RD;
  endproperty
  a_rd_ap: assert property (p_rd_ap) else $error("read command pins wrong");

  property p_pre_all;
    accept && op == sdrpi_pkg::OP_PRE |=> A_O[sdrpi_pkg::A10_BIT] == $past(REQ_I.all_banks) &&
                                         BA_O == $past(REQ_I.bank);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge a10 or bank wrong");

  property p_wr_chop;
    accept && op == sdrpi_pkg::OP_WR |=> A_O[sdrpi_pkg::A12_BIT] == !$past(REQ_I.bc4);
  endproperty
  a_wr_chop: assert property (p_wr_chop) else $error("write a12 chop bit wrong");

  property p_mrs_sel;
    accept && op == sdrpi_pkg::OP_MRS |=> BA_O == {1'b0, $past(REQ_I.mr_sel)} && A_O == $past(REQ_I.addr);
  endproperty
  a_mrs_sel: assert property (p_mrs_sel) else $error("load mode target or opcode wrong");

  sequence s_hold;
    $stable(CS_N_O) && $stable(RAS_N_O) && $stable(CAS_N_O) && $stable(WE_N_O) && $stable(A_O);
  endsequence

  // a non-burst command may follow at the very next ck, replacing the deselect
  property p_cmd_hold;
    accept |=> ##1 s_hold ##1 s_hold ##1 s_hold ##1 (CS_N_O == sdrpi_pkg::CS_NONE || $past(accept));
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held one ck");

  property p_pd_entry;
    accept && cke_down |=> !CKE_O[$past(REQ_I.rank)];
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("cke not lowered on entry");

  property p_mem_rst;
    MEM_RST_I |=> !RESET_N_O;
  endproperty
  a_mem_rst: assert property (p_mem_rst) else $error("reset pin not asserted");

endmodule : sdrpi_host
`default_nettype wire

// ==== dv/sdrpi_dev_model.sv ====
// behavioural two-rank sdram device seen at its pins
`timescale 1ns/1ps
`default_nettype none
module sdrpi_dev_model (
  input  wire logic        clk_i,
  input  wire logic        ck_i,
  input  wire logic [1:0]  cke_i,
  input  wire logic [1:0]  cs_n_i,
  input  wire logic [2:0]  rcw_i,
  input  wire logic [2:0]  ba_i,
  input  wire logic [15:0] a_i,
  input  wire logic        reset_n_i,
  input  wire logic        dm_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        dq_oe_n_i,
  input  wire logic        dqs_i,
  output logic      [7:0]  dq_o
);
  logic [7:0] mem [int];
  logic [1:0] sel;
  int         base, n, len;
  assign sel = cke_i & ~cs_n_i;
  initial dq_o = 8'h00;
  always @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) mem.delete();
    else if (sel == 2'h1 || sel == 2'h2) begin
      base = int'({sel[1], ba_i, a_i[9:0], 3'h0});
      len = a_i[12] ? 8 : 4;
      n = 0;
      if (rcw_i == sdrpi_pkg::RCW_RD) begin
        repeat (sdrpi_pkg::CL_CK - 1) @(posedge ck_i);
        repeat (4) @(posedge clk_i);  // beat 0 starts on the ck edge that ends the latency
        for (int k = 0; k < len; k++) begin
          #1 dq_o = mem.exists(base + k) ? mem[base + k] : 8'h5a;
          repeat (2) @(posedge clk_i);
        end
        #1 dq_o = ~dq_o;  // released bus must not keep the last beat
      end else if (rcw_i != sdrpi_pkg::RCW_WR) n = 8;
    end
  end
  // centred strobe: data is stable at both edges
  always @(posedge dqs_i or negedge dqs_i)
    if (!dq_oe_n_i && n < len) begin
      if (!dm_i) mem[base + n] = dq_i;
      n++;
    end
endmodule : sdrpi_dev_model
`default_nettype wire

// ==== dv/sdram_dual_rank_pin_interface_tb.sv ====
// self-checking bench: host controller against a pin-level device model
`timescale 1ns/1ps
`default_nettype none
module sdram_dual_rank_pin_interface_tb;
  localparam logic [63:0] WA = 64'h0123456789abcdef;
  localparam logic [63:0] WB = 64'hfedcba9876543210;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, rvalid, ready, busy, ck, dm, oe_n, dqs, rst_o, ras, cas, we;
  sdrpi_pkg::sdrpi_req_t req = '0;
  logic [63:0] rdata;
  logic        ck_n, dqs_n, dqs_oe_n, mem_rst = 1'b0;
  logic [1:0]  cke, cs_n, odt, odt_en = 2'h0;
  logic [2:0]  ba;
  logic [15:0] a;
  logic [7:0]  dq_h, dq_d;
  int          failures = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  sdrpi_host i_dut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .REQ_I(req), .REQ_VALID_I(valid), .REQ_READY_O(ready),
    .ODT_EN_I(odt_en), .MEM_RST_I(mem_rst), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .BUSY_O(busy), .CK_O(ck),
    .CK_N_O(ck_n), .CKE_O(cke), .CS_N_O(cs_n), .RAS_N_O(ras), .CAS_N_O(cas), .WE_N_O(we), .BA_O(ba), .A_O(a),
    .ODT_O(odt), .RESET_N_O(rst_o), .DM_O(dm), .DQ_I(dq_d), .DQ_O(dq_h), .DQ_OE_N_O(oe_n), .DQS_O(dqs),
    .DQS_N_O(dqs_n), .DQS_OE_N_O(dqs_oe_n));
  sdrpi_dev_model i_dev (.clk_i(clk), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .rcw_i({ras, cas, we}),
    .ba_i(ba), .a_i(a), .reset_n_i(rst_o), .dm_i(dm), .dq_i(dq_h), .dq_oe_n_i(oe_n), .dqs_i(dqs), .dq_o(dq_d));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one request; bc4 and auto-precharge follow the expected a12 and a10 levels
  task automatic issue(input sdrpi_pkg::sdrpi_op_t op, input logic rk, input logic [2:0] bk,
                       input logic [15:0] ad, input logic [63:0] wd, input logic [7:0] wm,
                       input logic [2:0] rcw, input logic [15:0] ea);
    int t;
    req <= '{op: op, rank: rk, bank: bk, addr: ad, auto_pre: ea[10], bc4: ~ea[12], all_banks: ad[10],
             mr_sel: bk[1:0], wdata: wd, wmask: wm};
    valid <= 1'b1;
    t = 0;
    do @(posedge clk); while (ready !== 1'b1 && t++ < 50);
    if (ready !== 1'b1) t = 300;
    valid <= 1'b0;
    @(posedge ck);
    if (op < sdrpi_pkg::OP_PDE || op == sdrpi_pkg::OP_SRE)
      chk(64'({cs_n, ras, cas, we, ba, a}), 64'({~(rk ? 2'h2 : 2'h1), rcw, bk, ea}));
    while (op == sdrpi_pkg::OP_RD && rvalid !== 1'b1 && t++ < 300) @(posedge clk);
    while (busy !== 1'b0 && t++ < 300) @(posedge clk);
    if (t >= 300) begin
      failures++;
      $display("mismatch at %0t: request timed out", $time);
    end
  endtask : issue
  task automatic t_power;
    issue(sdrpi_pkg::OP_PDX, 1'b0, 3'h0, 16'h0000, WA, 8'h00, 3'h7, 16'h1000);
    issue(sdrpi_pkg::OP_PDX, 1'b1, 3'h0, 16'h0000, WA, 8'h00, 3'h7, 16'h1000);
    chk(64'(cke), 64'h3);
    issue(sdrpi_pkg::OP_SRE, 1'b1, 3'h0, 16'h0000, WA, 8'h00, 3'h1, 16'h0000);
    issue(sdrpi_pkg::OP_PDE, 1'b0, 3'h0, 16'h0000, WA, 8'h00, 3'h7, 16'h1000);
    chk(64'(cke), 64'h0);
    issue(sdrpi_pkg::OP_SRX, 1'b1, 3'h0, 16'h0000, WA, 8'h00, 3'h7, 16'h1000);
    issue(sdrpi_pkg::OP_PDX, 1'b0, 3'h0, 16'h0000, WA, 8'h00, 3'h7, 16'h1000);
    chk(64'(cke), 64'h3);
  endtask : t_power
  task automatic t_mask;
    issue(sdrpi_pkg::OP_ACT, 1'b0, 3'h5, 16'h1234, WA, 8'h00, 3'h3, 16'h1234);
    issue(sdrpi_pkg::OP_WR, 1'b0, 3'h5, 16'h0010, WA, 8'h00, 3'h4, 16'h1010);
    issue(sdrpi_pkg::OP_WR, 1'b0, 3'h5, 16'h0010, WB, 8'h24, 3'h4, 16'h1010);
    issue(sdrpi_pkg::OP_RD, 1'b0, 3'h5, 16'h0010, WA, 8'h00, 3'h5, 16'h1010);
    chk(rdata, 64'hfedc459876ab3210);
  endtask : t_mask
  task automatic t_rank;
    issue(sdrpi_pkg::OP_WR, 1'b1, 3'h5, 16'h0010, WA, 8'h00, 3'h4, 16'h0010);
    issue(sdrpi_pkg::OP_RD, 1'b1, 3'h5, 16'h0010, WA, 8'h00, 3'h5, 16'h0010);
    chk(64'(rdata[31:0]), 64'h89abcdef);
    issue(sdrpi_pkg::OP_RD, 1'b0, 3'h5, 16'h0010, WA, 8'h00, 3'h5, 16'h1410);
    chk(rdata, 64'hfedc459876ab3210);
  endtask : t_rank
  task automatic t_ctl;
    issue(sdrpi_pkg::OP_PRE, 1'b0, 3'h3, 16'h0000, WA, 8'h00, 3'h2, 16'h0000);
    issue(sdrpi_pkg::OP_PRE, 1'b1, 3'h0, 16'h0400, WA, 8'h00, 3'h2, 16'h0400);
    issue(sdrpi_pkg::OP_MRS, 1'b0, 3'h2, 16'h0a5c, WA, 8'h00, 3'h0, 16'h0a5c);
    chk(64'(rst_o), 64'h1);
    odt_en <= 2'h2;
    repeat (5) @(posedge clk);
    chk(64'(odt), 64'h2);
    chk(64'({ck ^ ck_n, dqs ^ dqs_n, oe_n ^ dqs_oe_n}), 64'h6);
    mem_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(64'(rst_o), 64'h0);
    mem_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(64'(rst_o), 64'h1);
  endtask : t_ctl
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_mask();
    t_rank();
    t_ctl();
    test_done();
  end
endmodule : sdram_dual_rank_pin_interface_tb
`default_nettype wire
